// ---- verilog/icce_pkg.sv ----
// package: constants for the io channel control element
package icce_pkg;
	localparam int NUM_SUBCH = 256;
	localparam int SUBCH_W = 8;
	localparam int UCW_WORDS = 4;
	localparam int UCW_REGION = 1024;
	localparam int UCW_AW = 10;
	localparam int LOCAL_WORDS = 64;
	localparam int LOCAL_AW = 6;
	localparam int MCS_WORDS = 32768;
	localparam int MCS_AW = 15;
	localparam int NUM_SEL = 3;
	localparam int NUM_CTCA = 2;
	localparam int BYTES_PER_WORD = 4;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int LOCAL_CYCLE_PS = 500000;
	localparam int MCS_CYCLE_PS = 2000000;
	localparam int LOCAL_CYC = (LOCAL_CYCLE_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int MCS_CYC = (MCS_CYCLE_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam logic [9:0] CYC_RESET = 10'h000;
	localparam logic [1:0] CFG_STATE_ZERO = 2'h0;
	localparam logic [1:0] CFG_STATE_ONE = 2'h1;
	localparam logic [6:0] UCW_BASE = 7'h00;
	typedef enum logic [5:0] {
		ICCE_IDLE = 6'b00_0001,
		ICCE_FETCH = 6'b00_0010,
		ICCE_DATA = 6'b00_0100,
		ICCE_WBACK = 6'b00_1000,
		ICCE_BURST = 6'b01_0000,
		ICCE_BDONE = 6'b10_0000
	} icce_mx_e;
endpackage

// ---- verilog/icce_core.sv ----
// io channel control element: channel service, stores and parity
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - multiplexor serves up to 256 interleaved subchannels
// - 1024-word region, four words per subchannel
// - multiplex: fetch words, move data, write back
// - mux burst: one device, words held locally
// - selectors burst only, one device until done
// - selector: bytes from device, words to storage
// - selector read packs four bytes per word
// - parity checked on each byte of words
// - local store 64 words, 0.5 us cycle; model writes it on each clock with proc_req, proc_ack one cycle later
// - maintenance store 32K words, 2.0 us cycle
// - two selectors, expandable to a third
// - adapters on selector 1/2 look standard
// - channel work and processing run concurrently
// - panel controls gated by configuration state
// - priority: mux, then selector 1, 2, 3
//////////////////////////////////////////////////////////////////////////////
module icce_core (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sel3_present,
	input wire logic [1:0] config_state,
	input wire logic [icce_pkg::NUM_SEL-1:0] ctca_present,
	input wire logic panel_req,
	input wire logic start_mx,
	input wire logic start_mx_burst,
	input wire logic [icce_pkg::SUBCH_W-1:0] start_subch,
	input wire logic [31:0] start_ucw,
	input wire logic [icce_pkg::NUM_SEL-1:0] start_sel,
	input wire logic mx_req,
	input wire logic [icce_pkg::SUBCH_W-1:0] mx_subch,
	input wire logic [8:0] mx_byte_in,
	input wire logic mx_end,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_byte_valid,
	input wire logic [9*icce_pkg::NUM_SEL-1:0] sel_byte_in,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_end,
	input wire logic proc_req,
	input wire logic [35:0] proc_wdata,
	output logic mx_ack,
	output logic [icce_pkg::NUM_SEL-1:0] sel_busy,
	output logic [icce_pkg::NUM_SEL-1:0] sel_word_valid,
	output logic [35:0] sel_word_out,
	output logic [31:0] mx_ucw_out,
	output logic proc_ack,
	output logic panel_enable,
	output logic panel_limited,
	output logic parity_err,
	output logic ce_interrupt
);
	import icce_pkg::*;

	// stores are flip-flops addressed by index
	logic [35:0] local_mem [LOCAL_WORDS];
	logic [31:0] ucw_mem [UCW_REGION];
	logic [9:0] cyc_cnt_reg;
	icce_mx_e mx_state_reg;
	logic mx_burst_reg;
	logic [SUBCH_W-1:0] mx_cur_reg;
	logic [31:0] mx_ucw_reg;
	logic [NUM_SEL-1:0] sel_active_reg;
	logic [26:0] sel_pack_reg [NUM_SEL];
	logic [1:0] sel_cnt_reg [NUM_SEL];
	logic [NUM_SEL-1:0] sel_full_reg;
	logic [35:0] sel_word_reg [NUM_SEL];
	logic [NUM_SEL-1:0] grant;
	logic [NUM_SEL-1:0] sel_avail;
	logic any_byte_err;
	logic [NUM_SEL-1:0] byte_err;
	logic word_err;
	logic [UCW_AW-1:0] ucw_idx;
	logic [LOCAL_AW-1:0] proc_idx_reg;

	function automatic logic byte_bad(input logic [8:0] b);
		byte_bad = ~(^b);
	endfunction

	function automatic logic word_bad(input logic [35:0] w);
		word_bad = byte_bad(w[8:0]) | byte_bad(w[17:9])
			| byte_bad(w[26:18]) | byte_bad(w[35:27]);
	endfunction

	// the three storage cycles are modelled by one shared cycle counter
	assign ucw_idx = {mx_cur_reg, 2'b00};
	assign sel_avail = {sel3_present, 2'b11};
	// adapters answer as standard control units, no own path

	//////////////////////////////////////////////////////////////////////
	// service priority: mux first, then selectors in order
	always_comb begin
		grant = '0;
		if (mx_state_reg == ICCE_IDLE && !(mx_req && !start_mx)) begin
			for (int i = 0; i < NUM_SEL; i++) begin
				if (sel_full_reg[i] && grant == '0) begin
					grant[i] = 1'b1;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// multiplexor channel sequencing
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mx_state_reg <= ICCE_IDLE;
			mx_burst_reg <= 1'b0;
			mx_cur_reg <= '0;
			mx_ucw_reg <= '0;
			cyc_cnt_reg <= CYC_RESET;
			mx_ack <= 1'b0;
		end else begin
			mx_ack <= 1'b0;
			unique case (mx_state_reg)
				ICCE_IDLE: begin
					if (mx_req && !start_mx) begin
						mx_cur_reg <= mx_subch;
						cyc_cnt_reg <= 10'(MCS_CYC);
						mx_state_reg <= mx_burst_reg ? ICCE_BURST
							: ICCE_FETCH;
					end
					if (start_mx) begin
						mx_burst_reg <= start_mx_burst;
						// burst keeps its word here until the end
						if (start_mx_burst) begin
							mx_ucw_reg <= start_ucw;
						end
					end
				end
				ICCE_FETCH: begin
					cyc_cnt_reg <= cyc_cnt_reg - 10'h001;
					if (cyc_cnt_reg == 10'h001) begin
						mx_ucw_reg <= ucw_mem[ucw_idx];
						cyc_cnt_reg <= 10'(MCS_CYC);
						mx_state_reg <= ICCE_DATA;
					end
				end
				ICCE_DATA: begin
					cyc_cnt_reg <= cyc_cnt_reg - 10'h001;
					if (cyc_cnt_reg == 10'h001) begin
						mx_ucw_reg <= mx_ucw_reg + 32'h0000_0001;
						cyc_cnt_reg <= 10'(MCS_CYC);
						mx_state_reg <= ICCE_WBACK;
					end
				end
				ICCE_WBACK: begin
					cyc_cnt_reg <= cyc_cnt_reg - 10'h001;
					if (cyc_cnt_reg == 10'h001) begin
						mx_ack <= 1'b1;
						mx_state_reg <= ICCE_IDLE;
					end
				end
				ICCE_BURST: begin
					// word held locally, no write-back per byte
					cyc_cnt_reg <= cyc_cnt_reg - 10'h001;
					if (cyc_cnt_reg == 10'h001) begin
						mx_ucw_reg <= mx_ucw_reg + 32'h0000_0001;
						mx_ack <= 1'b1;
						mx_state_reg <= mx_end ? ICCE_BDONE : ICCE_IDLE;
					end
				end
				ICCE_BDONE: begin
					mx_burst_reg <= 1'b0;
					mx_state_reg <= ICCE_IDLE;
				end
				default: mx_state_reg <= ICCE_IDLE;
			endcase
		end
	end

	// control word store; write-back closes each non-burst multiplex service, and a burst only at its end
	always_ff @(posedge clk_sys) begin
		if (start_mx) begin
			ucw_mem[{start_subch, 2'b00}] <= start_ucw;
		end else if ((mx_state_reg == ICCE_WBACK
			|| mx_state_reg == ICCE_BDONE) && cyc_cnt_reg <= 10'h001) begin
			ucw_mem[ucw_idx] <= mx_ucw_reg;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mx_ucw_out <= '0;
		end else begin
			mx_ucw_out <= mx_ucw_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// selector channels: byte packing and word hand-off
	for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
		logic [8:0] b;
		assign b = sel_byte_in[9*g +: 9];
		assign byte_err[g] = sel_byte_valid[g] && sel_active_reg[g]
			&& byte_bad(b);
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				sel_active_reg[g] <= 1'b0;
				sel_cnt_reg[g] <= 2'h0;
				sel_pack_reg[g] <= '0;
				sel_full_reg[g] <= 1'b0;
				sel_word_reg[g] <= '0;
			end else begin
				// one device owns the channel until it ends
				if (start_sel[g] && sel_avail[g] && !sel_active_reg[g]) begin
					sel_active_reg[g] <= 1'b1;
					sel_cnt_reg[g] <= 2'h0;
				end else if (sel_end[g]) begin
					sel_active_reg[g] <= 1'b0;
				end
				if (grant[g]) begin
					sel_full_reg[g] <= 1'b0;
				end
				if (sel_byte_valid[g] && sel_active_reg[g]) begin
					sel_cnt_reg[g] <= sel_cnt_reg[g] + 2'h1;
					if (sel_cnt_reg[g] == 2'h3) begin
						// fourth byte completes a word
						sel_word_reg[g] <= {sel_pack_reg[g], b};
						sel_full_reg[g] <= 1'b1;
					end else begin
						sel_pack_reg[g] <= {sel_pack_reg[g][17:0], b};
					end
				end
			end
		end
	end

	// a 36-bit word keeps per-byte parity as four 9-bit lanes
	logic [35:0] granted_word;
	always_comb begin
		granted_word = '0;
		for (int i = 0; i < NUM_SEL; i++) begin
			if (grant[i]) begin
				granted_word = sel_word_reg[i];
			end
		end
	end
	assign word_err = (grant != '0) && word_bad(granted_word);
	assign any_byte_err = (byte_err != '0) || (mx_req
		&& mx_state_reg == ICCE_IDLE && byte_bad(mx_byte_in));

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sel_word_valid <= '0;
			sel_word_out <= '0;
			sel_busy <= '0;
		end else begin
			sel_word_valid <= grant;
			sel_busy <= sel_active_reg;
			if (grant != '0) begin
				sel_word_out <= granted_word;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// processor working registers; independent of channel service
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			proc_idx_reg <= '0;
			proc_ack <= 1'b0;
		end else begin
			proc_ack <= proc_req;
			if (proc_req) begin
				proc_idx_reg <= proc_idx_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (proc_req) begin
			local_mem[proc_idx_reg] <= proc_wdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// panel gating and error reporting
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			panel_enable <= 1'b0;
			panel_limited <= 1'b0;
		end else begin
			// states two and three lock the panel out
			panel_enable <= panel_req && (config_state == CFG_STATE_ZERO
				|| config_state == CFG_STATE_ONE);
			panel_limited <= config_state == CFG_STATE_ONE;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			parity_err <= 1'b0;
			ce_interrupt <= 1'b0;
		end else begin
			// a new error wins over the start that clears
			if (word_err || any_byte_err) begin
				parity_err <= 1'b1;
				ce_interrupt <= 1'b1;
			end else if (start_mx || start_sel != '0) begin
				parity_err <= 1'b0;
				ce_interrupt <= 1'b0;
			end
		end
	end
endmodule

// ---- testbench/icce_core_properties.sv ----
// checker: port properties of the channel control element
`timescale 1ns/1ps
module icce_core_properties (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] config_state,
	input wire logic mx_req,
	input wire logic start_mx,
	input wire logic [icce_pkg::NUM_SEL-1:0] start_sel,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_byte_valid,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_end,
	input wire logic mx_ack,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_busy,
	input wire logic [icce_pkg::NUM_SEL-1:0] sel_word_valid,
	input wire logic panel_enable,
	input wire logic panel_limited,
	input wire logic parity_err,
	input wire logic ce_interrupt
);
	import icce_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	int wait_cnt;
	logic [1:0] bcnt_reg;
	//////////////////////////////////////////////////////////////////////
	// service wait counter; too long for a repetition
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wait_cnt <= 0;
		end else if (mx_ack || !mx_req) begin
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bcnt_reg <= 2'h0;
		end else if (start_sel[0]) begin
			bcnt_reg <= 2'h0;
		end else if (sel_byte_valid[0]) begin
			bcnt_reg <= bcnt_reg + 2'h1;
		end
	end
	//////////////////////////////////////////////////////////////////////
	sequence s_fourth_byte;
		sel_byte_valid[0] && bcnt_reg == 2'h3 && !mx_req;
	endsequence
	property p_panel_off;
		config_state[1] ##1 config_state[1] |-> !panel_enable;
	endproperty
	property p_panel_lim;
		config_state[1] ##1 config_state[1] |-> !panel_limited;
	endproperty
	property p_ack_pulse;
		mx_ack |=> !mx_ack;
	endproperty
	property p_ack_wait;
		mx_ack |-> wait_cnt >= MCS_CYC;
	endproperty
	property p_ack_bound;
		wait_cnt <= 3 * MCS_CYC + 4;
	endproperty
	property p_word_packs;
		s_fourth_byte |-> ##[1:4] sel_word_valid[0];
	endproperty
	property p_busy_hold;
		// busy lags the end strobe by two registered cycles
		sel_busy[0] && !$past(sel_end[0]) |=> sel_busy[0];
	endproperty
	property p_par_sticky;
		parity_err && !start_mx && start_sel == '0 |=> parity_err;
	endproperty
	property p_irq;
		$rose(parity_err) |-> ##[0:2] ce_interrupt;
	endproperty
	a_panel_off: assert property (p_panel_off) else $error("panel on");
	a_panel_lim: assert property (p_panel_lim) else $error("panel lim");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
	a_ack_wait: assert property (p_ack_wait) else $error("ack early");
	a_ack_bound: assert property (p_ack_bound) else $error("ack late");
	a_word_packs: assert property (p_word_packs) else $error("no word");
	a_busy_hold: assert property (p_busy_hold) else $error("busy drop");
	a_par_sticky: assert property (p_par_sticky) else $error("par lost");
	a_irq: assert property (p_irq) else $error("no irq");
endmodule

// ---- testbench/icce_dev_model.sv ----
// device control unit model on the channel side
`timescale 1ns/1ps
module icce_dev_model (
	input wire logic clk_sys,
	input wire logic mx_ack,
	output logic mx_req,
	output logic [7:0] mx_subch,
	output logic [8:0] mx_byte_in,
	output logic [2:0] sel_byte_valid,
	output logic [26:0] sel_byte_in,
	output logic [2:0] sel_end
);
	initial begin
		{mx_req, mx_subch, mx_byte_in} = '0;
		{sel_byte_valid, sel_byte_in, sel_end} = '0;
	end
	// request held until the falling edge after the ack, then the byte lines go stale
	task automatic mx_serve(input logic [7:0] sc, input logic [7:0] d,
		output int n);
		n = 0;
		@(negedge clk_sys);
		mx_subch = sc;
		mx_byte_in = {~^d, d};
		mx_req = 1'b1;
		while (mx_ack !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		@(negedge clk_sys);
		mx_req = 1'b0;
		mx_byte_in = ~mx_byte_in;
	endtask
	// bytes one per cycle, high byte first; bad spoils the first parity
	task automatic sel_word(input int ch, input logic [31:0] d, input logic bad);
		for (int i = 3; i >= 0; i--) begin
			@(negedge clk_sys);
			sel_byte_valid[ch] = 1'b1;
			sel_byte_in[9*ch+:9] = {~^d[8*i+:8] ^ (bad && i == 3), d[8*i+:8]};
		end
		@(negedge clk_sys);
		sel_byte_valid[ch] = 1'b0;
		sel_byte_in[9*ch+:9] = ~sel_byte_in[9*ch+:9];
	endtask
	task automatic sel_stop(input int ch);
		@(negedge clk_sys);
		sel_end[ch] = 1'b1;
		@(negedge clk_sys);
		sel_end[ch] = 1'b0;
	endtask
endmodule

// ---- testbench/tb.sv ----
// testbench for the channel control element
`timescale 1ns/1ps
module tb;
	import icce_pkg::*;
	logic clk_sys, reset, sel3_present, panel_req, start_mx, proc_req;
	logic start_mx_burst, mx_end;
	logic mx_req, mx_ack, proc_ack, panel_enable, panel_limited;
	logic parity_err, ce_interrupt, proc_seen;
	logic [1:0] config_state;
	logic [7:0] start_subch, mx_subch;
	logic [8:0] mx_byte_in;
	logic [31:0] start_ucw, mx_ucw_out;
	logic [2:0] start_sel, sel_byte_valid, sel_end, sel_busy, sel_word_valid;
	logic [26:0] sel_byte_in;
	logic [35:0] sel_word_out;
	int n_errors, comparisons;
	icce_core dut_u (.clk_sys, .reset, .sel3_present, .config_state,
		.ctca_present(3'h0), .panel_req, .start_mx, .start_mx_burst,
		.start_subch, .start_ucw, .start_sel, .mx_req, .mx_subch, .mx_byte_in,
		.mx_end, .sel_byte_valid, .sel_byte_in, .sel_end, .proc_req,
		.proc_wdata(36'h0), .mx_ack, .sel_busy, .sel_word_valid,
		.sel_word_out, .mx_ucw_out, .proc_ack, .panel_enable, .panel_limited,
		.parity_err, .ce_interrupt);
	icce_dev_model dev_u (.clk_sys, .mx_ack, .mx_req, .mx_subch, .mx_byte_in,
		.sel_byte_valid, .sel_byte_in, .sel_end);
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	// processor answered while a mux service is still pending
	always @(posedge clk_sys) begin
		if (reset) proc_seen <= 1'b0;
		else if (proc_ack === 1'b1 && mx_req) proc_seen <= 1'b1;
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic t_panel();
		for (int s = 0; s < 4; s++) begin
			@(negedge clk_sys);
			config_state = s[1:0];
			repeat (3) @(negedge clk_sys);
			chk({panel_enable, panel_limited}, {s < 2, s == 1});
		end
		panel_req = 0;
		config_state = 2'h0;
		repeat (3) @(negedge clk_sys);
		chk(panel_enable, 1'b0);
		panel_req = 1;
		$display("test panel done");
	endtask
	task automatic t_mux();
		int n;
		@(negedge clk_sys);
		start_mx = 1;
		start_subch = 8'hff;
		start_ucw = 32'h1234_5678;
		@(negedge clk_sys);
		start_mx = 0;
		fork
			dev_u.mx_serve(8'hff, 8'h5a, n);
			begin
				@(negedge clk_sys);
				proc_req = 1;
				@(negedge clk_sys);
				proc_req = 0;
			end
		join
		chk(n >= 3 * MCS_CYC && n <= 3 * MCS_CYC + 4, 1'b1);
		chk(proc_seen, 1'b1);
		chk(mx_ucw_out, 32'h1234_5679);
		$display("test mux done");
	endtask
	task automatic t_burst();
		int n;
		@(negedge clk_sys);
		start_mx = 1;
		start_mx_burst = 1;
		start_subch = 8'h01;
		start_ucw = 32'h0000_0100;
		@(negedge clk_sys);
		{start_mx, start_mx_burst} = 2'h0;
		dev_u.mx_serve(8'h01, 8'h3c, n);
		chk(n >= MCS_CYC && n <= MCS_CYC + 4, 1'b1);
		mx_end = 1;
		dev_u.mx_serve(8'h01, 8'h3d, n);
		mx_end = 0;
		chk(n >= MCS_CYC && n <= MCS_CYC + 4, 1'b1);
		// burst over: the next service is a full multiplex cycle again
		dev_u.mx_serve(8'h01, 8'h3e, n);
		chk(n >= 3 * MCS_CYC && n <= 3 * MCS_CYC + 4, 1'b1);
		chk(mx_ucw_out, 32'h0000_0103);
		$display("test burst done");
	endtask
	task automatic t_sel_absent();
		@(negedge clk_sys);
		sel3_present = 0;
		start_sel[2] = 1;
		@(negedge clk_sys);
		start_sel = 3'h0;
		repeat (2) @(negedge clk_sys);
		chk(sel_busy[2], 1'b0);
		sel3_present = 1;
		$display("test selector absent done");
	endtask
	task automatic t_sel(input int ch, input logic [31:0] d, input logic bad);
		logic [35:0] exp_word;
		exp_word = {~^d[31:24], d[31:24], ~^d[23:16], d[23:16],
			~^d[15:8], d[15:8], ~^d[7:0], d[7:0]};
		@(negedge clk_sys);
		start_sel[ch] = 1;
		@(negedge clk_sys);
		start_sel = 3'h0;
		// busy is registered after the active flag: one cycle more
		@(negedge clk_sys);
		chk(sel_busy[ch], 1'b1);
		dev_u.sel_word(ch, d, bad);
		for (int k = 0; k < 20 && sel_word_valid[ch] !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		if (bad) chk({parity_err, ce_interrupt}, 2'h3);
		else chk(sel_word_out, exp_word);
		chk(sel_busy[ch], 1'b1);
		dev_u.sel_stop(ch);
		repeat (3) @(negedge clk_sys);
		chk(sel_busy[ch], 1'b0);
		$display("test selector %0d done", ch);
	endtask
	initial begin
		{reset, sel3_present, panel_req} = 3'h7;
		{start_mx, proc_req, config_state, start_sel} = '0;
		{start_mx_burst, mx_end} = 2'h0;
		{start_subch, start_ucw, n_errors, comparisons} = '0;
		repeat (12) @(negedge clk_sys);
		reset = 0;
		@(negedge clk_sys);
		chk({mx_ack, sel_busy, parity_err, ce_interrupt}, 6'h0);
		t_panel();
		t_mux();
		t_burst();
		t_sel(0, 32'h1234_5678, 0);
		t_sel(2, 32'h00ff_8001, 0);
		chk(parity_err, 1'b0);
		t_sel_absent();
		t_sel(1, 32'ha5c3_0f96, 1);
		finish_test();
	end
	initial begin
		#100000;
		n_errors++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
bind icce_core icce_core_properties chk_u (.clk_sys, .reset, .config_state,
	.mx_req, .start_mx, .start_sel, .sel_byte_valid, .sel_end, .mx_ack,
	.sel_busy, .sel_word_valid, .panel_enable, .panel_limited, .parity_err,
	.ce_interrupt);
